// ===== hdl/dual_counter_transmit_demod.sv
`timescale 1ns/10ps
// Counter pair: waveform generation in transmit, edge timing in demodulation
module dual_counter_transmit_demod (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic first_demod_input_pin,
  input wire logic second_demod_input_pin,
  input wire logic port_data_out,
  output logic combined_output_pin,
  output logic short_counter_output,
  output logic long_counter_output,
  output logic long_capture_irq,
  output logic pin_capture_interrupt
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] short_ctrl_reg; // Short counter control
  logic [7:0] common_ctrl_reg; // Bits 7:2 of common control; 1:0 unused
  logic [1:0] init_level_reg; // Initial output levels, transmit meaning
  logic rise_flag_reg; // Rising edge detected
  logic fall_flag_reg; // Falling edge detected
  logic [7:0] long_counter_control_reg;
  logic [7:0] short_reload_reg;
  logic [7:0] long_reload_low_reg;
  logic [7:0] long_reload_high_reg;
  logic [7:0] capture_low_byte_reg;
  logic [7:0] capture_high_byte_reg;
  logic [15:0] long_counter_reg;
  logic [7:0] short_counter_reg;
  logic short_out_reg;
  logic long_out_reg;
  logic ping_turn_reg; // High while the long counter holds the turn
  logic filt_dly_reg; // Previous filtered input level
  logic short_run_dly_reg; // Enable history to preload on start
  logic long_run_dly_reg;
  logic long_capture_irq_reg;
  logic pin_irq_reg;
  dual_counter_pkg::demod_state_e demod_state_reg;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic demod_mode = common_ctrl_reg[dual_counter_pkg::MODE_BIT] != 1'b0;
  wire logic sel_bit = common_ctrl_reg[dual_counter_pkg::SELECT_BIT];
  wire logic [1:0] edge_sel = common_ctrl_reg[dual_counter_pkg::EDGE_HI:dual_counter_pkg::EDGE_LO];
  wire logic [1:0] sub_sel = common_ctrl_reg[dual_counter_pkg::SUB_HI:dual_counter_pkg::SUB_LO];
  wire logic long_en = long_counter_control_reg[dual_counter_pkg::LONG_ENABLE_BIT];
  wire logic short_en = short_ctrl_reg[dual_counter_pkg::SHORT_ENABLE_BIT];
  wire logic wr_common = reg_write && (reg_addr == dual_counter_pkg::ADDR_COMMON_CTRL);
  wire logic [15:0] long_reload = {long_reload_high_reg, long_reload_low_reg};
  wire logic ping_pong = sub_sel == dual_counter_pkg::SUB_PING_PONG;
  wire logic [1:0] filter_sel = demod_mode ? sub_sel : dual_counter_pkg::FILT_NONE;

  ////////////////////////////////////////////////////////////////////////
  // Demodulation input path
  // Input chosen by the select bit in demodulation mode
  wire logic demod_raw = sel_bit ? second_demod_input_pin : first_demod_input_pin;
  wire logic filt_level;

  demod_glitch_filter u_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw_in(demod_raw),
    .filter_sel(filter_sel),
    .filtered_out(filt_level)
  );

  wire logic rise_seen = filt_level && !filt_dly_reg;
  wire logic fall_seen = !filt_level && filt_dly_reg;
  // Polarity that qualifies; reserved code accepts both edges
  wire logic rise_ok = rise_seen && (edge_sel != dual_counter_pkg::EDGE_FALLING);
  wire logic fall_ok = fall_seen && (edge_sel != dual_counter_pkg::EDGE_RISING);
  wire logic qual_edge = demod_mode && long_en && (rise_ok || fall_ok);
  // Later edges capture only while capture mode bit is clear
  wire logic capture = qual_edge && ((demod_state_reg == dual_counter_pkg::DEMOD_WAIT_FIRST) ||
                       !long_counter_control_reg[dual_counter_pkg::CAPTURE_MODE_BIT]);

  ////////////////////////////////////////////////////////////////////////
  // Transmit counting
  wire logic long_run = !demod_mode && long_en && (!ping_pong || ping_turn_reg);
  wire logic short_run = !demod_mode && short_en && (!ping_pong || !ping_turn_reg);
  wire logic long_start = long_run && !long_run_dly_reg;
  wire logic short_start = short_run && !short_run_dly_reg;
  // Timeout only when stepping from one; zero steps to full silently
  wire logic long_timeout = long_run && !long_start && (long_counter_reg == dual_counter_pkg::LONG_ONE);
  wire logic short_timeout = short_run && !short_start && (short_counter_reg == dual_counter_pkg::SHORT_ONE);
  wire logic [15:0] long_dec = (long_counter_reg == dual_counter_pkg::LONG_ZERO) ?
                               dual_counter_pkg::LONG_FULL : long_counter_reg - 16'h0001;
  wire logic [7:0] short_dec = (short_counter_reg == dual_counter_pkg::SHORT_ZERO) ?
                               dual_counter_pkg::SHORT_FULL : short_counter_reg - 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Submodes 10 and 11 hold the long output at a fixed level in transmit only;
  // in demodulation the same bits are the filter code and must not touch the pin
  wire logic long_level = demod_mode ? long_out_reg :
                          (sub_sel == dual_counter_pkg::SUB_FORCE_LOW) ? 1'b0 :
                          (sub_sel == dual_counter_pkg::SUB_FORCE_HIGH) ? 1'b1 : long_out_reg;
  assign short_counter_output = short_out_reg;
  assign long_counter_output = long_level;
  // Combined output merges both counters when selected in transmit
  assign combined_output_pin = (!demod_mode && sel_bit) ?
                               (short_out_reg | long_level) : port_data_out;
  assign long_capture_irq = long_capture_irq_reg;
  assign pin_capture_interrupt = pin_irq_reg;

  // Readback of bits 1:0 changes meaning with mode
  wire logic [1:0] low_bits = demod_mode ? {rise_flag_reg, fall_flag_reg} : init_level_reg;
  always_comb begin
    case (reg_addr)
      dual_counter_pkg::ADDR_SHORT_CTRL: reg_rdata = short_ctrl_reg;
      dual_counter_pkg::ADDR_COMMON_CTRL: reg_rdata = {common_ctrl_reg[7:2], low_bits};
      dual_counter_pkg::ADDR_LONG_CTRL: reg_rdata = long_counter_control_reg;
      dual_counter_pkg::ADDR_SHORT_RELOAD: reg_rdata = short_reload_reg;
      dual_counter_pkg::ADDR_LONG_RELOAD_LOW: reg_rdata = long_reload_low_reg;
      dual_counter_pkg::ADDR_LONG_RELOAD_HIGH: reg_rdata = long_reload_high_reg;
      dual_counter_pkg::ADDR_CAPTURE_LOW: reg_rdata = capture_low_byte_reg;
      dual_counter_pkg::ADDR_CAPTURE_HIGH: reg_rdata = capture_high_byte_reg;
      default: reg_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  // Plain writable registers; capture bytes are read only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      short_ctrl_reg <= dual_counter_pkg::CTRL_RESET;
      common_ctrl_reg <= dual_counter_pkg::CTRL_RESET;
      init_level_reg <= 2'h0;
      long_counter_control_reg <= dual_counter_pkg::CTRL_RESET;
      short_reload_reg <= dual_counter_pkg::RELOAD8_RESET;
      long_reload_low_reg <= dual_counter_pkg::RELOAD8_RESET;
      long_reload_high_reg <= dual_counter_pkg::RELOAD8_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        dual_counter_pkg::ADDR_SHORT_CTRL: short_ctrl_reg <= reg_wdata;
        dual_counter_pkg::ADDR_COMMON_CTRL: begin
          common_ctrl_reg <= {reg_wdata[7:2], 2'h0};
          // Initial levels are stored only in transmit mode
          if (!demod_mode) begin
            init_level_reg <= reg_wdata[1:0];
          end
        end
        dual_counter_pkg::ADDR_LONG_CTRL: long_counter_control_reg <= reg_wdata;
        dual_counter_pkg::ADDR_SHORT_RELOAD: short_reload_reg <= reg_wdata;
        dual_counter_pkg::ADDR_LONG_RELOAD_LOW: long_reload_low_reg <= reg_wdata;
        dual_counter_pkg::ADDR_LONG_RELOAD_HIGH: long_reload_high_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Edge flags: a capture in the clearing cycle keeps its flag set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rise_flag_reg <= 1'b0;
      fall_flag_reg <= 1'b0;
    end else begin
      if (capture && rise_seen) begin
        rise_flag_reg <= 1'b1;
      end else if (wr_common && demod_mode && reg_wdata[dual_counter_pkg::INIT_SHORT_BIT]) begin
        rise_flag_reg <= 1'b0;
      end
      if (capture && fall_seen) begin
        fall_flag_reg <= 1'b1;
      end else if (wr_common && demod_mode && reg_wdata[dual_counter_pkg::INIT_LONG_BIT]) begin
        fall_flag_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Demodulation capture
  // First edge loads the counter; the capture stores the complement
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      demod_state_reg <= dual_counter_pkg::DEMOD_WAIT_FIRST;
      capture_low_byte_reg <= 8'h00;
      capture_high_byte_reg <= 8'h00;
      long_capture_irq_reg <= 1'b0;
      pin_irq_reg <= 1'b0;
      filt_dly_reg <= 1'b0;
    end else begin
      filt_dly_reg <= filt_level;
      long_capture_irq_reg <= capture &&
                              long_counter_control_reg[dual_counter_pkg::IRQ_ENABLE_BIT];
      pin_irq_reg <= capture && sel_bit;
      if (capture) begin
        {capture_high_byte_reg, capture_low_byte_reg} <= ~long_counter_reg;
      end
      case (demod_state_reg)
        dual_counter_pkg::DEMOD_WAIT_FIRST: begin
          if (qual_edge) begin
            demod_state_reg <= dual_counter_pkg::DEMOD_MEASURE;
          end
        end
        dual_counter_pkg::DEMOD_MEASURE: begin
          // Disabling or leaving demodulation rearms the first edge
          if (!demod_mode || !long_en) begin
            demod_state_reg <= dual_counter_pkg::DEMOD_WAIT_FIRST;
          end
        end
        default: demod_state_reg <= dual_counter_pkg::DEMOD_WAIT_FIRST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters and waveform outputs
  // Counters load on start; outputs sit at the initial level while disabled or in demodulation
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      long_counter_reg <= dual_counter_pkg::COUNT_RESET;
      short_counter_reg <= 8'h00;
      long_out_reg <= 1'b0;
      short_out_reg <= 1'b0;
      ping_turn_reg <= 1'b0;
      long_run_dly_reg <= 1'b0;
      short_run_dly_reg <= 1'b0;
    end else begin
      long_run_dly_reg <= long_run;
      short_run_dly_reg <= short_run;
      // Long counter
      if (demod_mode) begin
        if (capture) begin
          long_counter_reg <= (demod_state_reg == dual_counter_pkg::DEMOD_WAIT_FIRST) ?
                              long_reload : dual_counter_pkg::LONG_FULL;
        end else if (long_en && demod_state_reg == dual_counter_pkg::DEMOD_MEASURE) begin
          long_counter_reg <= long_dec;
        end
      end else if (long_start || long_timeout) begin
        long_counter_reg <= long_reload;
      end else if (long_run) begin
        long_counter_reg <= long_dec;
      end
      if (!long_en || demod_mode) begin
        long_out_reg <= init_level_reg[dual_counter_pkg::INIT_LONG_BIT];
      end else if (long_timeout) begin
        long_out_reg <= !long_out_reg;
      end
      // Short counter
      if (short_start || short_timeout) begin
        short_counter_reg <= short_reload_reg;
      end else if (short_run) begin
        short_counter_reg <= short_dec;
      end
      if (!short_en || demod_mode) begin
        short_out_reg <= init_level_reg[dual_counter_pkg::INIT_SHORT_BIT];
      end else if (short_timeout) begin
        short_out_reg <= !short_out_reg;
      end
      // Ping-pong hands the turn over on each timeout
      if (!ping_pong || demod_mode) begin
        ping_turn_reg <= 1'b0;
      end else if (short_timeout || long_timeout) begin
        ping_turn_reg <= !ping_turn_reg;
      end
    end
  end
endmodule : dual_counter_transmit_demod

// ===== hdl/dual_counter_pkg.sv
package dual_counter_pkg;
  // Register offsets in the counter bank
  localparam logic [3:0] ADDR_SHORT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COMMON_CTRL = 4'h1;
  localparam logic [3:0] ADDR_LONG_CTRL = 4'h2;
  localparam logic [3:0] ADDR_SHORT_RELOAD = 4'h4;
  localparam logic [3:0] ADDR_LONG_RELOAD_LOW = 4'h5;
  localparam logic [3:0] ADDR_LONG_RELOAD_HIGH = 4'h6;
  localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h7;
  localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h8;
  // Common control field positions
  localparam int MODE_BIT = 7;
  localparam int SELECT_BIT = 6;
  localparam int EDGE_HI = 5;
  localparam int EDGE_LO = 4;
  localparam int SUB_HI = 3;
  localparam int SUB_LO = 2;
  localparam int INIT_SHORT_BIT = 1;
  localparam int INIT_LONG_BIT = 0;
  // Long counter control field positions
  localparam int LONG_ENABLE_BIT = 7;
  localparam int CAPTURE_MODE_BIT = 6;
  localparam int IRQ_ENABLE_BIT = 2;
  // Short counter control field position
  localparam int SHORT_ENABLE_BIT = 7;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RELOAD8_RESET = 8'hff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Counter constants
  localparam logic [15:0] LONG_FULL = 16'hffff;
  localparam logic [15:0] LONG_ONE = 16'h0001;
  localparam logic [15:0] LONG_ZERO = 16'h0000;
  localparam logic [7:0] SHORT_ONE = 8'h01;
  localparam logic [7:0] SHORT_ZERO = 8'h00;
  localparam logic [7:0] SHORT_FULL = 8'hff;
  // Transmit submodes
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PING_PONG = 2'h1;
  localparam logic [1:0] SUB_FORCE_LOW = 2'h2;
  localparam logic [1:0] SUB_FORCE_HIGH = 2'h3;
  // Glitch filter choices and lengths in clocks
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_FOUR = 2'h1;
  localparam logic [1:0] FILT_EIGHT = 2'h2;
  localparam logic [3:0] FILT_FOUR_CLOCKS = 4'h4;
  localparam logic [3:0] FILT_EIGHT_CLOCKS = 4'h8;
  // Qualifying edge choices
  localparam logic [1:0] EDGE_FALLING = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  // Demodulation sequencing states
  typedef enum logic [1:0] {
    DEMOD_WAIT_FIRST = 2'b01,
    DEMOD_MEASURE = 2'b10
  } demod_state_e;
endpackage : dual_counter_pkg

// ===== hdl/demod_glitch_filter.sv
`timescale 1ns/10ps
// Accepts a new input level only after it has held for the chosen length
module demod_glitch_filter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic raw_in,
  input wire logic [1:0] filter_sel,
  output logic filtered_out
);
  logic [3:0] stable_reg; // Clocks the differing level has held
  logic level_reg; // Accepted level
  wire logic [3:0] need_len; // Required hold length
  wire logic differs;
  wire logic accept;

  // Reserved code behaves as no filter
  assign need_len = (filter_sel == dual_counter_pkg::FILT_FOUR) ?
                    dual_counter_pkg::FILT_FOUR_CLOCKS :
                    dual_counter_pkg::FILT_EIGHT_CLOCKS;
  assign differs = raw_in != level_reg;
  assign accept = differs && ((filter_sel == dual_counter_pkg::FILT_NONE) ||
                  (filter_sel == 2'h3) || (stable_reg + 4'h1 >= need_len));
  assign filtered_out = level_reg;

  // Count consecutive clocks of a changed level, restart on any bounce
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stable_reg <= 4'h0;
      level_reg <= 1'b0;
    end else if (accept) begin
      stable_reg <= 4'h0;
      level_reg <= raw_in;
    end else if (differs) begin
      stable_reg <= stable_reg + 4'h1;
    end else begin
      stable_reg <= 4'h0;
    end
  end
endmodule : demod_glitch_filter

// ===== testbench/dual_counter_sva.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Port checker; shadows the control bits that steer the outputs
module dual_counter_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic first_demod_input_pin,
  input wire logic second_demod_input_pin,
  input wire logic port_data_out,
  input wire logic combined_output_pin,
  input wire logic short_counter_output,
  input wire logic long_counter_output,
  input wire logic long_capture_irq,
  input wire logic pin_capture_interrupt
);
  logic [7:0] common_reg; // Shadow of common control; flag bits unused
  logic [7:0] long_reg; // Shadow of long counter control
  wire tx = !common_reg[dual_counter_pkg::MODE_BIT]; // Transmit mode
  wire sel = common_reg[dual_counter_pkg::SELECT_BIT]; // Pin select
  wire [1:0] sub = common_reg[3:2]; // Submode or filter code
  // Shadows take writes at the same edge the block does
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      common_reg <= 8'h00;
      long_reg <= 8'h00;
    end else if (reg_write && reg_addr == dual_counter_pkg::ADDR_COMMON_CTRL) begin
      common_reg <= reg_wdata;
    end else if (reg_write && reg_addr == dual_counter_pkg::ADDR_LONG_CTRL) begin
      long_reg <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_combined_mux: assert property (tx && sel |->
    combined_output_pin == (short_counter_output | long_counter_output))
    else $error("combined pin is not the OR of both outputs");
  a_port_passthru: assert property (!(tx && sel) |->
    combined_output_pin == port_data_out) else $error("combined pin lost port data");
  a_forced_low: assert property (tx && sub == 2'h2 |-> !long_counter_output)
    else $error("long output not forced low");
  a_forced_high: assert property (tx && sub == 2'h3 |-> long_counter_output)
    else $error("long output not forced high");
  a_pin_irq_select: assert property (pin_capture_interrupt |-> !$past(tx) && $past(sel))
    else $error("pin interrupt without second input selected");
  a_first_capture: assert property (!tx && !sel && common_reg[5:4] == 2'h1
    && sub == 2'h0 && long_reg[7] && !long_reg[6] && long_reg[2]
    && $rose(first_demod_input_pin)
    |-> ##2 long_capture_irq) else $error("rising edge not captured in two cycles");
  a_flag_with_irq: assert property (long_capture_irq && reg_addr == 4'h1
    |-> reg_rdata[1:0] != 2'h0) else $error("capture without edge flag");
  a_irq_enabled: assert property (long_capture_irq |-> $past(long_reg[2]) && !$past(tx))
    else $error("capture pulse while disabled");
endmodule : dual_counter_sva
bind dual_counter_transmit_demod dual_counter_sva i_sva (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .first_demod_input_pin(first_demod_input_pin),
  .second_demod_input_pin(second_demod_input_pin), .port_data_out(port_data_out),
  .combined_output_pin(combined_output_pin), .short_counter_output(short_counter_output),
  .long_counter_output(long_counter_output), .long_capture_irq(long_capture_irq),
  .pin_capture_interrupt(pin_capture_interrupt));

// ===== testbench/demod_signal_source.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Far-side pulse source on the two demodulation inputs
module demod_signal_source (
  input wire logic clk,
  output logic first_pin,
  output logic second_pin
);
  // Lines idle low until a burst is commanded
  initial begin
    first_pin = 1'b0;
    second_pin = 1'b0;
  end
  // Holds one line at a level for whole clocks; changes only at the falling edge
  task automatic hold(input logic which, input logic lvl, input int clocks);
    @(negedge clk);
    if (which) begin
      second_pin = lvl;
    end else begin
      first_pin = lvl;
    end
    repeat (clocks - 1) @(negedge clk);
  endtask : hold
endmodule : demod_signal_source

// ===== testbench/dual_counter_transmit_demod_test.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Bench: register access, transmit levels, wrap, edge capture, filter
module dual_counter_transmit_demod_test;
  logic clk, sys_rst, reg_write, port_data_out, pin_a, pin_b;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic comb_pin, short_out, long_out, long_irq, pin_irq;
  int err_total, checked, long_seen, pin_seen;
  dual_counter_transmit_demod i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .first_demod_input_pin(pin_a), .second_demod_input_pin(pin_b),
    .port_data_out(port_data_out), .combined_output_pin(comb_pin),
    .short_counter_output(short_out), .long_counter_output(long_out),
    .long_capture_irq(long_irq), .pin_capture_interrupt(pin_irq));
  demod_signal_source i_src (.clk(clk), .first_pin(pin_a), .second_pin(pin_b));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pulse counters, so one-cycle interrupts are never missed
  always @(posedge clk) begin
    if (long_irq === 1'b1) long_seen++;
    if (pin_irq === 1'b1) pin_seen++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_count(input int got, input int exp);
    checked++;
    if (got != exp) begin
      err_total++;
      $display("BAD %0t pulses %0d expected %0d", $time, got, exp);
    end
  endtask : chk_count
  // One-cycle write strobe; address rests on common control
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_addr = 4'h1;
  endtask : wr
  // Read data is combinational, so no clock is spent
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr = a;
    #2;
    chk_byte(reg_rdata, exp);
  endtask : rd
  task automatic do_reset();
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [3:0] addrs [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
    logic [7:0] vals [9] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rd(addrs[i], vals[i]);
  endtask : t_reset_values
  task automatic t_transmit_levels();
    wr(4'h1, 8'h03);
    rd(4'h1, 8'h03);
    @(negedge clk);
    chk_bit(short_out, 1'b1);
    chk_bit(long_out, 1'b1);
    wr(4'h1, 8'h08);
    chk_bit(long_out, 1'b0);
    wr(4'h1, 8'h4c);
    chk_bit(comb_pin, 1'b1);
    wr(4'h1, 8'h0c);
    chk_bit(long_out, 1'b1);
    port_data_out = 1'b1;
    #2 chk_bit(comb_pin, 1'b1);
    @(negedge clk);
    port_data_out = 1'b0;
    #2 chk_bit(comb_pin, 1'b0);
  endtask : t_transmit_levels
  task automatic t_zero_wrap();
    int n;
    wr(4'h1, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    wr(4'h2, 8'h80);
    repeat (40) begin
      @(negedge clk);
      chk_bit(long_out, 1'b0);
    end
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h03);
    wr(4'h2, 8'h80);
    n = 0;
    while (long_out === 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk_bit(long_out, 1'b1);
    wr(4'h2, 8'h00);
  endtask : t_zero_wrap
  // Ping-pong: short runs first, each timeout hands the turn over
  task automatic t_ping_pong();
    wr(4'h1, 8'h44);
    wr(4'h4, 8'h02);
    wr(4'h2, 8'h80);
    wr(4'h0, 8'h80);
    repeat (3) @(negedge clk);
    chk_bit(short_out, 1'b1);
    chk_bit(long_out, 1'b0);
    chk_bit(comb_pin, 1'b1);
    repeat (4) @(negedge clk);
    chk_bit(long_out, 1'b1);
    chk_bit(short_out, 1'b1);
    repeat (3) @(negedge clk);
    chk_bit(short_out, 1'b0);
    chk_bit(long_out, 1'b1);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h00);
  endtask : t_ping_pong
  // Counter starts from zero after reset, so the first capture is all ones
  task automatic t_demod_capture();
    wr(4'h5, 8'hff);
    wr(4'h6, 8'hff);
    wr(4'h1, 8'h90);
    wr(4'h2, 8'h84);
    i_src.hold(1'b0, 1'b1, 6);
    rd(4'h8, 8'hff);
    rd(4'h7, 8'hff);
    i_src.hold(1'b0, 1'b0, 14);
    i_src.hold(1'b0, 1'b1, 6);
    rd(4'h8, 8'h00);
    rd(4'h7, 8'h13);
    rd(4'h1, 8'h92);
    wr(4'h1, 8'h90);
    rd(4'h1, 8'h92);
    wr(4'h1, 8'h92);
    rd(4'h1, 8'h90);
  endtask : t_demod_capture
  // Interrupt enable off here: captures set flags but raise no pulse
  task automatic t_edge_polarity();
    int s;
    wr(4'h2, 8'h80);
    s = long_seen;
    wr(4'h1, 8'h80);
    i_src.hold(1'b0, 1'b0, 6);
    rd(4'h1, 8'h81);
    wr(4'h1, 8'ha1);
    i_src.hold(1'b0, 1'b1, 6);
    rd(4'h1, 8'ha2);
    i_src.hold(1'b0, 1'b0, 6);
    rd(4'h1, 8'ha3);
    chk_count(long_seen, s);
    wr(4'h2, 8'h84);
  endtask : t_edge_polarity
  task automatic t_second_input();
    int s;
    wr(4'h1, 8'hd3);
    s = pin_seen;
    i_src.hold(1'b0, 1'b1, 6);
    chk_count(pin_seen, s);
    i_src.hold(1'b1, 1'b1, 6);
    chk_count(pin_seen, s + 1);
    rd(4'h1, 8'hd2);
  endtask : t_second_input
  // Glitch of 2 under the short filter, of 6 under the long one, is dropped
  task automatic t_glitch_filter(input logic [7:0] cfg, input int glitch);
    int s;
    wr(4'h1, cfg);
    i_src.hold(1'b0, 1'b0, 14);
    s = long_seen;
    i_src.hold(1'b0, 1'b1, glitch);
    i_src.hold(1'b0, 1'b0, 14);
    chk_count(long_seen, s);
    i_src.hold(1'b0, 1'b1, 14);
    chk_count(long_seen, s + 1);
  endtask : t_glitch_filter
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Watchdog: the sequence needs well under 1000 clocks
  initial begin
    #(4000 * 25);
    err_total++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    reg_addr = 4'h1;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    port_data_out = 1'b0;
    err_total = 0;
    checked = 0;
    long_seen = 0;
    pin_seen = 0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_reset_values();
    t_transmit_levels();
    t_zero_wrap();
    t_ping_pong();
    do_reset();
    t_demod_capture();
    t_edge_polarity();
    t_second_input();
    t_glitch_filter(8'h97, 2);
    t_glitch_filter(8'h9b, 6);
    test_done();
  end
endmodule : dual_counter_transmit_demod_test
